// *** common/iofd_defines.vh ***
`ifndef IOFD_DEFINES_VH
`define IOFD_DEFINES_VH
`define IOFD_ADR_CTRL       32'h0000_0000
`define IOFD_ADR_INSN       32'h0000_0004
`define IOFD_ADR_DEC0       32'h0000_0008
`define IOFD_ADR_DEC1       32'h0000_000C
`define IOFD_ADR_DEC2       32'h0000_0010
`define IOFD_ADR_TABLE_POINTER     32'h0000_0014
`define IOFD_ADR_PROD       32'h0000_0018
`define IOFD_ADR_LATCH      32'h0000_001C
`define IOFD_ADR_BANK       32'h0000_0020
`define IOFD_FMT_BYTE       3'h0
`define IOFD_FMT_BIT        3'h1
`define IOFD_FMT_LIT8       3'h2
`define IOFD_FMT_LIT12      3'h3
`define IOFD_FMT_LIT20      3'h4
`define IOFD_FMT_BRREL      3'h5
`define IOFD_FMT_MOVE       3'h6
`define IOFD_FMT_INDEX      3'h7
`define IOFD_STEP_NONE      2'h0
`define IOFD_STEP_POSTINC   2'h1
`define IOFD_STEP_POSTDEC   2'h2
`define IOFD_STEP_PREINC    2'h3
`define IOFD_SECOND_TAG     4'hF
`define IOFD_ACCESS_SPLIT   8'h80
`define IOFD_ACCESS_HIBANK  4'hF
`define IOFD_RST_BANK       4'h0
`endif

// *** src/iofd_decoder.v ***
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "iofd_defines.vh"
module iofd_decoder (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output wire        wb_err_o
);
  // ****************************************
  // reset synchroniser
  // ****************************************
  reg rst_s1_q;
  reg rst_s2_q;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  wire rst_n = rst_s2_q;

  // ****************************************
  // registers
  // ****************************************
  reg [2:0]  fmt_q;
  reg [15:0] word0_q;
  reg [15:0] word1_q;
  reg [3:0]  bank_q;
  reg [20:0] table_pointer_q;
  reg [7:0]  prod_hi_q;
  reg [7:0]  prod_lo_q;
  reg [7:0]  pc_hi_latch_q;
  reg [7:0]  pc_up_latch_q;
  reg [7:0]  table_latch_q;

  // ****************************************
  // field decode
  // ****************************************
  wire        dest_sel;
  wire        access_sel;
  wire [7:0]  file_addr;
  wire [2:0]  bit_index;
  wire [7:0]  bit_mask;
  wire [1:0]  ptr_sel;
  wire [11:0] data_addr;
  wire        second_word;
  wire        second_ok;

  iofd_word_split u_split (
    .word        (word0_q),
    .bank        (bank_q),
    .dest_sel    (dest_sel),
    .access_sel  (access_sel),
    .file_addr   (file_addr),
    .bit_index   (bit_index),
    .bit_mask    (bit_mask),
    .ptr_sel     (ptr_sel),
    .data_addr   (data_addr),
    .second_word (second_word)
  );

  assign second_ok = (word1_q[15:12] == `IOFD_SECOND_TAG);

  wire [11:0] move_src  = word0_q[11:0];
  wire [11:0] move_dst  = word1_q[11:0];
  wire [6:0]  ofs_src   = word0_q[13:7];
  wire [6:0]  ofs_dst   = word0_q[6:0];
  wire [1:0]  tbl_step  = word0_q[1:0];
  // the fast mode bit sits just above the low operand byte of a call
  wire        fast_sel  = word0_q[8];

  // literal width chosen by format; upper 12 bits from the second word for LIT20 only
  reg [19:0] literal;
  always @* begin
    case (fmt_q)
      `IOFD_FMT_LIT12: literal = {8'h00, word0_q[11:0]};
      `IOFD_FMT_LIT20: literal = {word1_q[11:0], word0_q[7:0]};
      default:         literal = {12'h000, word0_q[7:0]};
    endcase
  end

  // relative offset sign-extended; absolute target taken as is
  wire [19:0] jump_target = (fmt_q == `IOFD_FMT_BRREL) ?
                            {{12{word0_q[7]}}, word0_q[7:0]} : literal;
  wire        jump_rel    = (fmt_q == `IOFD_FMT_BRREL);

  // lone second word is a no-op
  wire is_nop = second_word;
  wire wr_acc = !is_nop && (fmt_q == `IOFD_FMT_BYTE) && !dest_sel;
  wire wr_reg = !is_nop && (fmt_q == `IOFD_FMT_BYTE) && dest_sel;
  wire shadow_use = !is_nop && fast_sel;

  wire [20:0] tbl_access;
  wire [20:0] tbl_next;
  iofd_table_step u_step (
    .ptr         (table_pointer_q),
    .step        (tbl_step),
    .access_addr (tbl_access),
    .next_ptr    (tbl_next)
  );

  // ****************************************
  // wishbone slave
  // ****************************************
  wire req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr     = req && wb_we_i;
  wire hit    = (wb_adr_i == `IOFD_ADR_CTRL)   || (wb_adr_i == `IOFD_ADR_INSN) ||
                (wb_adr_i == `IOFD_ADR_DEC0)   || (wb_adr_i == `IOFD_ADR_DEC1) ||
                (wb_adr_i == `IOFD_ADR_DEC2)   || (wb_adr_i == `IOFD_ADR_TABLE_POINTER) ||
                (wb_adr_i == `IOFD_ADR_PROD)   || (wb_adr_i == `IOFD_ADR_LATCH) ||
                (wb_adr_i == `IOFD_ADR_BANK);
  assign wb_err_o = 1'b0;

  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        lane_merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  wire [31:0] ctrl_rd   = {29'h0, fmt_q};
  wire [31:0] insn_rd   = {word1_q, word0_q};
  wire [31:0] tbl_rd    = {3'h0, table_latch_q, table_pointer_q};
  wire [31:0] prod_rd   = {16'h0, prod_hi_q, prod_lo_q};
  wire [31:0] latch_rd  = {16'h0, pc_up_latch_q, pc_hi_latch_q};
  wire [31:0] bank_rd   = {28'h0, bank_q};
  wire [31:0] ctrl_m    = lane_merge(ctrl_rd,  wb_dat_i, wb_sel_i);
  wire [31:0] insn_m    = lane_merge(insn_rd,  wb_dat_i, wb_sel_i);
  wire [31:0] tbl_m     = lane_merge(tbl_rd,   wb_dat_i, wb_sel_i);
  wire [31:0] prod_m    = lane_merge(prod_rd,  wb_dat_i, wb_sel_i);
  wire [31:0] latch_m   = lane_merge(latch_rd, wb_dat_i, wb_sel_i);
  wire [31:0] bank_m    = lane_merge(bank_rd,  wb_dat_i, wb_sel_i);

  // decoded views
  wire [31:0] dec0 = {wr_acc, wr_reg, access_sel, is_nop, second_ok, bit_index,
                      bit_mask, ptr_sel, data_addr, 2'h0};
  wire [31:0] dec1 = {move_dst, move_src, ofs_src[6:0], shadow_use};
  wire [31:0] dec2 = {jump_rel, 1'b0, tbl_step, jump_target, file_addr};

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fmt_q         <= `IOFD_FMT_BYTE;
      word0_q       <= 16'h0000;
      word1_q       <= 16'h0000;
      bank_q        <= `IOFD_RST_BANK;
      table_pointer_q      <= 21'h000000;
      prod_hi_q     <= 8'h00;
      prod_lo_q     <= 8'h00;
      pc_hi_latch_q <= 8'h00;
      pc_up_latch_q <= 8'h00;
      table_latch_q <= 8'h00;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        case (wb_adr_i)
          `IOFD_ADR_CTRL:   wb_dat_o <= ctrl_rd;
          `IOFD_ADR_INSN:   wb_dat_o <= insn_rd;
          `IOFD_ADR_DEC0:   wb_dat_o <= dec0;
          `IOFD_ADR_DEC1:   wb_dat_o <= dec1;
          `IOFD_ADR_DEC2:   wb_dat_o <= {ofs_dst[6:0], dec2[24:0]};
          `IOFD_ADR_TABLE_POINTER: wb_dat_o <= tbl_rd;
          `IOFD_ADR_PROD:   wb_dat_o <= prod_rd;
          `IOFD_ADR_LATCH:  wb_dat_o <= latch_rd;
          `IOFD_ADR_BANK:   wb_dat_o <= bank_rd;
          default:          wb_dat_o <= 32'h0000_0000;
        endcase
      end
      if (wr && hit) begin
        case (wb_adr_i)
          `IOFD_ADR_CTRL: begin
            fmt_q <= ctrl_m[2:0];
          end
          `IOFD_ADR_INSN: begin
            word0_q <= insn_m[15:0];
            word1_q <= insn_m[31:16];
          end
          `IOFD_ADR_TABLE_POINTER: begin
            table_pointer_q      <= tbl_m[20:0];
            table_latch_q <= tbl_m[28:21];
          end
          `IOFD_ADR_PROD: begin
            prod_lo_q <= prod_m[7:0];
            prod_hi_q <= prod_m[15:8];
          end
          `IOFD_ADR_LATCH: begin
            pc_hi_latch_q <= latch_m[7:0];
            pc_up_latch_q <= latch_m[15:8];
          end
          `IOFD_ADR_BANK: begin
            bank_q <= bank_m[3:0];
          end
          default: begin
            fmt_q <= fmt_q;
          end
        endcase
      end else if (req && !wb_we_i && (wb_adr_i == `IOFD_ADR_DEC2)) begin
        // reading the step view performs the table step; ignored bits are unused
        table_pointer_q <= tbl_next;
      end
    end
  end

  // table access address for the current step, not exposed through the dec views; only reduced into unused_ok
  wire unused_ok = ^tbl_access;
endmodule
`default_nettype wire

// *** src/iofd_table_step.v ***
`timescale 1ns/1ps
`default_nettype none
`include "iofd_defines.vh"
module iofd_table_step (
  input  wire [20:0] ptr,
  input  wire [1:0]  step,
  output reg  [20:0] access_addr,
  output reg  [20:0] next_ptr
);
  // ****************************************
  // table pointer step
  // ****************************************
  always @* begin
    access_addr = ptr;
    next_ptr    = ptr;
    case (step)
      `IOFD_STEP_NONE: begin
        next_ptr = ptr;
      end
      `IOFD_STEP_POSTINC: begin
        next_ptr = ptr + 21'h1;
      end
      `IOFD_STEP_POSTDEC: begin
        next_ptr = ptr - 21'h1;
      end
      default: begin
        access_addr = ptr + 21'h1;
        next_ptr    = ptr + 21'h1;
      end
    endcase
  end
endmodule
`default_nettype wire

// *** src/iofd_word_split.v ***
`timescale 1ns/1ps
`default_nettype none
`include "iofd_defines.vh"
module iofd_word_split (
  input  wire [15:0] word,
  input  wire [3:0]  bank,
  output wire        dest_sel,
  output wire        access_sel,
  output wire [7:0]  file_addr,
  output wire [2:0]  bit_index,
  output wire [7:0]  bit_mask,
  output wire [1:0]  ptr_sel,
  output wire [11:0] data_addr,
  output wire        second_word
);
  // ****************************************
  // field split
  // ****************************************
  assign dest_sel    = word[9];
  assign access_sel  = word[8];
  assign file_addr   = word[7:0];
  assign bit_index   = word[11:9];
  assign bit_mask    = 8'h01 << bit_index;
  assign ptr_sel     = word[1:0];
  assign second_word = (word[15:12] == `IOFD_SECOND_TAG);
  // access RAM maps low half to bank 0, upper half to the top bank
  assign data_addr = access_sel ? {bank, file_addr} :
                     {(file_addr < `IOFD_ACCESS_SPLIT) ? 4'h0 : `IOFD_ACCESS_HIBANK,
                      file_addr};
endmodule
`default_nettype wire

// *** test/iofd_decoder_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iofd_defines.vh"
module iofd_decoder_checker (
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o
);
  // ****************
  // bus and decode checks
  // ****************
  logic take;
  logic rd_dec0;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd_dec0 = take && !wb_we_i && wb_adr_i == `IOFD_ADR_DEC0;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  property p_ack_next; take |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("no ack one cycle after request");
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_ack_cause; wb_ack_o |-> $past(take); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_no_err; wb_err_o == 1'b0; endproperty
  a_no_err: assert property (p_no_err)
    else $error("error response raised");
  property p_hold; !(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o); endproperty
  a_hold: assert property (p_hold)
    else $error("read data changed while idle");
  property p_unmapped;
    take && !wb_we_i && wb_adr_i == 32'h0000_0024 |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_bit_mask; rd_dec0 |=> wb_dat_o[23:16] == (8'h01 << wb_dat_o[26:24]); endproperty
  a_bit_mask: assert property (p_bit_mask)
    else $error("bit mask does not match bit index");
  property p_access_bank;
    rd_dec0 ##1 !wb_dat_o[29] |-> wb_dat_o[13:10] == {4{wb_dat_o[9]}};
  endproperty
  a_access_bank: assert property (p_access_bank)
    else $error("access window bank wrong");
  c_write: cover property (take && wb_we_i);
  c_read: cover property (take && !wb_we_i);
  c_dec0: cover property (rd_dec0);
endmodule
bind iofd_decoder iofd_decoder_checker i_chk (.core_clk, .rstn, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o);
`default_nettype wire

// *** test/iofd_decoder_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iofd_defines.vh"
module iofd_decoder_tb_top;
  // ****************
  // bench
  // ****************
  logic        core_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [31:0] adr = 32'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [31:0] got;
  logic [31:0] e0;
  logic [31:0] m0;
  logic [15:0] w0;
  logic [15:0] w1;
  logic        nop;
  int          fails = 0;
  int          n_compared = 0;
  always #2.5 core_clk = ~core_clk;
  iofd_decoder i_dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o());
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] act);
    n_compared++;
    if (act !== exp) begin
      fails++;
      $display("Error at %0t: expected %h got %h", $time, exp, act);
    end
  endtask
  // one classic cycle, waits for ack under a bound
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    got = rdat;
    if (n >= 50) begin
      fails++;
      tally_and_finish();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    xfer(1'b0, `IOFD_ADR_BANK, 32'h0);
    chk(32'h0, got);
    xfer(1'b0, `IOFD_ADR_INSN, 32'h0);
    chk(32'h0, got);
    $display("test reset_values done");
    xfer(1'b1, `IOFD_ADR_BANK, 32'h5);
    xfer(1'b1, `IOFD_ADR_TABLE_POINTER, 32'h001F_FFFF);
    xfer(1'b0, `IOFD_ADR_TABLE_POINTER, 32'h0);
    chk(32'h001F_FFFF, got & 32'h001F_FFFF);
    xfer(1'b1, `IOFD_ADR_PROD, 32'h0000_C3A5);
    xfer(1'b0, `IOFD_ADR_PROD, 32'h0);
    chk(32'h0000_C3A5, got & 32'h0000_FFFF);
    xfer(1'b1, `IOFD_ADR_LATCH, 32'h0000_1FA5);
    xfer(1'b0, `IOFD_ADR_LATCH, 32'h0);
    chk(32'h0000_1FA5, got & 32'h0000_FFFF);
    xfer(1'b1, 32'h0000_0024, 32'hFFFF_FFFF);
    xfer(1'b0, 32'h0000_0024, 32'h0);
    chk(32'h0, got);
    xfer(1'b0, `IOFD_ADR_BANK, 32'h0);
    chk(32'h5, got);
    $display("test registers done");
    for (int i = 0; i < 8; i++) begin
      w0 = {(i == 3) ? 4'hF : (i[2] ? 4'h8 : 4'h2), i[2:0], i[1] ^ i[2], 8'h5A + 8'(i) * 8'h25};
      w1 = i[0] ? 16'h0ABC : 16'hF123;
      xfer(1'b1, `IOFD_ADR_CTRL, {31'h0, i[2]});
      xfer(1'b1, `IOFD_ADR_INSN, {w1, w0});
      xfer(1'b0, `IOFD_ADR_DEC0, 32'h0);
      nop = (w0[15:12] == 4'hF);
      e0 = {~i[2] & ~nop & ~w0[9], ~i[2] & ~nop & w0[9], w0[8], nop, w1[15:12] == 4'hF,
        w0[11:9], 8'h01 << w0[11:9], w0[1:0],
        w0[8] ? {4'h5, w0[7:0]} : {{4{w0[7]}}, w0[7:0]}, 2'h0};
      m0 = 32'hFFFF_FFFF;
      chk(e0 & m0, got & m0);
      xfer(1'b0, `IOFD_ADR_DEC1, 32'h0);
      chk({w1[11:0], w0[11:0], w0[13:7], w0[8] & ~nop}, got);
    end
    $display("test decode done");
    xfer(1'b1, `IOFD_ADR_CTRL, 32'h5);
    for (int s = 0; s < 4; s++) begin
      w0 = {8'hD0, 1'b1, 5'h1A, s[1:0]};
      xfer(1'b1, `IOFD_ADR_TABLE_POINTER, 32'h0000_0100);
      xfer(1'b1, `IOFD_ADR_INSN, {16'h0, w0});
      xfer(1'b0, `IOFD_ADR_DEC2, 32'h0);
      chk({w0[6:0], {9{w0[7]}}, w0[7:0], w0[7:0]}, got);
      xfer(1'b0, `IOFD_ADR_TABLE_POINTER, 32'h0);
      e0 = (s == 0) ? 32'h0000_0100 : ((s == 2) ? 32'h0000_00FF : 32'h0000_0101);
      chk(e0, got & 32'h001F_FFFF);
    end
    w1 = 16'hF2C7;
    xfer(1'b1, `IOFD_ADR_CTRL, 32'h4);
    xfer(1'b1, `IOFD_ADR_INSN, {w1, w0});
    xfer(1'b0, `IOFD_ADR_DEC2, 32'h0);
    chk({w0[6:0], w1[8:0], w0[7:0], w0[7:0]}, got);
    $display("test step_and_target done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
